//--- pkg/erb_pkg.sv
// Constants, types and helpers shared by the small embedded RAM block.
// Assumes a single clock domain; the block's two clocks arrive as enables.
//
// Contract
// R1: 576 bits storage, simple dual-port separate ports
// R2: Shapes 512x1 through 32x18, parity in 9/18
// R3: SDP, single-port, FIFO, ROM, shift; no true dual-port
// R4: All sizes: memories with or without parity
// R5: SDP mixed widths; true dual-port mixed not here
// R6: Input clear immediate; output shows next edge (here rd_en_q clears too, so the output holds until a new read strobe)
// R7: Output clear immediately visible at outputs
// R8: Write strobe, data, address share one clock
// R9: Read address, strobe, output each clock-selectable
// R10: Only output register bypassable; inputs always registered
// R11: RAM/ROM contents preloadable before operation
// R12: Large block ROM: user writes once, disables
// R13: Clocks, strobes, clear from row clocks/local routing
// R14: 16 inputs each neighbour; outputs to both
// R15: Large block contents power up undefined
// R16: Medium block 4608 bits, all modes
// R17: Read latency: address edge, plus output edge
// R18: Write only on write-clock edge with strobe
package erb_pkg;

    // ***********************************************************
    // Geometry
    // ***********************************************************
    localparam int ERB_TOTAL_BITS = 576; // [R1]
    localparam int ERB_MED_BITS = 4608; // [R16]
    localparam int ERB_ROW_W = 18;
    localparam int ERB_ROWS = ERB_TOTAL_BITS / ERB_ROW_W;
    localparam int ERB_ROW_IDX_W = 5;
    localparam int ERB_ADDR_W = 9;
    localparam int ERB_CNT_W = 10;
    localparam int ERB_LINK_W = 16; // [R14]

    // ***********************************************************
    // Register map
    // ***********************************************************
    localparam logic [11:0] ERB_OFF_CTRL = 12'h000;
    localparam logic [11:0] ERB_OFF_STATUS = 12'h004;
    localparam logic [11:0] ERB_OFF_INIT_ADDR = 12'h008;
    localparam logic [11:0] ERB_OFF_INIT_DATA = 12'h00c;
    localparam int ERB_CTRL_W = 17;
    localparam int ERB_ST_EMPTY_BIT = 0;
    localparam int ERB_ST_FULL_BIT = 1;
    localparam int ERB_ST_CNT_LSB = 2;

    // ***********************************************************
    // Types
    // ***********************************************************
    typedef enum logic [4:0] {
        ERB_MODE_SDP = 5'h01,
        ERB_MODE_SP = 5'h02,
        ERB_MODE_FIFO = 5'h04,
        ERB_MODE_ROM = 5'h08,
        ERB_MODE_SHIFT = 5'h10
    } erb_mode_e;

    typedef enum logic [2:0] {
        ERB_SH_512X1 = 3'h0,
        ERB_SH_256X2 = 3'h1,
        ERB_SH_128X4 = 3'h2,
        ERB_SH_64X8 = 3'h3,
        ERB_SH_64X9 = 3'h4,
        ERB_SH_32X16 = 3'h5,
        ERB_SH_32X18 = 3'h6
    } erb_shape_e;

    // Bit order of the packed struct is the CTRL register layout
    typedef struct packed {
        logic run;
        logic out_clk_sel;
        logic rd_en_clk_sel;
        logic rd_addr_clk_sel;
        logic wr_clk_sel;
        logic out_bypass;
        logic [2:0] rd_shape;
        logic [2:0] wr_shape;
        logic [4:0] mode;
    } erb_ctrl_s;

    localparam erb_ctrl_s ERB_CTRL_RST = '{run: 1'b0, out_clk_sel: 1'b1,
        rd_en_clk_sel: 1'b0, rd_addr_clk_sel: 1'b0, wr_clk_sel: 1'b0,
        out_bypass: 1'b0, rd_shape: 3'h6, wr_shape: 3'h6, mode: 5'h01};

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [8:0] wr_addr;
        logic [8:0] rd_addr;
    } erb_user_s;

    // ***********************************************************
    // Shape helpers
    // ***********************************************************
    function automatic logic [4:0] erb_width(input logic [2:0] sh);
        case (sh)
            3'h0: erb_width = 5'h01;
            3'h1: erb_width = 5'h02;
            3'h2: erb_width = 5'h04;
            3'h3: erb_width = 5'h08;
            3'h4: erb_width = 5'h09;
            3'h5: erb_width = 5'h10;
            default: erb_width = 5'h12;
        endcase
    endfunction

    function automatic logic [9:0] erb_depth(input logic [2:0] sh);
        case (sh)
            3'h0: erb_depth = 10'h200;
            3'h1: erb_depth = 10'h100;
            3'h2: erb_depth = 10'h080;
            3'h3, 3'h4: erb_depth = 10'h040;
            default: erb_depth = 10'h020;
        endcase
    endfunction

endpackage

//--- logic/erb_port_reg.sv
// Input-side register of the RAM block with a choice of clock enable.
// Assumes both clock enables are one-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
module erb_port_reg #(
    parameter int W = 9
) (
    // Clock and clears
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    // Clock selection
    input wire logic ce0,
    input wire logic ce1,
    input wire logic sel,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Clear acts at once on the register itself
    always_ff @(posedge pclk or negedge presetn or posedge clr) begin
        if (!presetn) begin
            q <= '0;
        end else if (clr) begin
            q <= '0; // [R6]
        end else if (sel ? ce1 : ce0) begin
            q <= d; // [R9]
        end
    end
endmodule
`default_nettype wire

//--- logic/erb_lane.sv
// Maps a word address of a given shape onto an 18-bit storage row.
// Purely combinational; the caller holds the row and does the write.
`timescale 1ns/1ps
`default_nettype none
module erb_lane (
    // Shape and word address
    input wire logic [2:0] shape,
    input wire logic [8:0] addr,
    // Row contents and write word
    input wire logic [17:0] row_in,
    input wire logic [17:0] wdata,
    // Results
    output logic [4:0] row_idx,
    output logic [17:0] rdata,
    output logic [17:0] row_wr
);
    logic [4:0] w;
    logic par;
    logic [12:0] bitpos;
    logic [4:0] base;
    logic [4:0] d;
    logic [4:0] p;

    // Nine- and eighteen-bit shapes use parity bits 8 and 17; others skip them
    always_comb begin
        w = erb_pkg::erb_width(shape);
        par = (shape == erb_pkg::ERB_SH_64X9) || (shape == erb_pkg::ERB_SH_32X18); // [R2]
        bitpos = 13'(addr) * 13'(w);
        base = (par && w == 5'h09 && addr[0]) ? 5'h09 : 5'h00;
        if (par) begin
            row_idx = (w == 5'h09) ? addr[5:1] : addr[4:0];
        end else begin
            row_idx = bitpos[8:4];
        end
        rdata = '0;
        row_wr = row_in;
        d = '0;
        p = '0;
        for (int i = 0; i < 18; i++) begin
            d = 5'(bitpos[3:0]) + 5'(i);
            p = par ? (base + 5'(i)) : (d + {4'h0, d[3]}); // [R4]
            if (5'(i) < w) begin
                rdata[i] = row_in[p];
                row_wr[p] = wdata[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/erb_ram.sv
// Small embedded RAM block: 32 rows of 18 bits, five modes, APB control.
// Assumes clk0_ce and clk1_ce are the block's two clocks as pclk enables
// and that user-side inputs come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module erb_ram (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block clocks as enables and clears
    input wire logic clk0_ce,
    input wire logic clk1_ce,
    input wire logic in_clr,
    input wire logic out_clr,
    // Neighbour inputs and user strobes
    input wire logic [15:0] din_left,
    input wire logic [15:0] din_right,
    input wire erb_pkg::erb_user_s user,
    // Outputs to both neighbours and FIFO flags
    output logic [17:0] dout_left,
    output logic [17:0] dout_right,
    output logic fifo_full,
    output logic fifo_empty
);
    // ***********************************************************
    // Declarations
    // ***********************************************************
    logic [17:0] mem_q [erb_pkg::ERB_ROWS];
    erb_pkg::erb_ctrl_s ctrl_q;
    logic [4:0] init_row_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [17:0] dout_q;
    logic full_q;
    logic empty_q;
    logic [8:0] wr_ptr_q;
    logic [8:0] rd_ptr_q;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic [8:0] sh_ptr_q;
    logic [8:0] rd_addr_q;
    logic rd_en_q;
    logic [17:0] wr_word;
    logic [2:0] rd_shape;
    logic [9:0] wr_depth;
    logic [8:0] depth_last;
    logic wr_ce;
    logic rd_ce;
    logic out_ce;
    logic is_fifo;
    logic is_shift;
    logic is_sp;
    logic is_rom;
    logic wr_fire;
    logic push;
    logic pop;
    logic [8:0] wr_addr_eff;
    logic [8:0] rd_addr_in;
    logic [4:0] w_row;
    logic [17:0] w_row_wr;
    logic [4:0] r_row;
    logic [17:0] r_word;
    logic apb_access;
    logic apb_commit;
    logic [11:0] apb_off;
    logic preload_ok;

    // ***********************************************************
    // Mode decode
    // ***********************************************************
    // Unknown mode codes fall back to simple dual-port, read at the write shape
    always_comb begin
        is_fifo = 1'b0;
        is_shift = 1'b0;
        is_sp = 1'b0;
        is_rom = 1'b0;
        case (ctrl_q.mode)
            erb_pkg::ERB_MODE_SDP: is_sp = 1'b0; // [R1]
            erb_pkg::ERB_MODE_SP: is_sp = 1'b1; // [R3]
            erb_pkg::ERB_MODE_FIFO: is_fifo = 1'b1;
            erb_pkg::ERB_MODE_ROM: is_rom = 1'b1;
            erb_pkg::ERB_MODE_SHIFT: is_shift = 1'b1;
            default: is_sp = 1'b0;
        endcase
    end

    // Only simple dual-port may read at a width other than the write width
    assign rd_shape = (ctrl_q.mode == erb_pkg::ERB_MODE_SDP) ? ctrl_q.rd_shape
                                                             : ctrl_q.wr_shape; // [R5]
    assign wr_depth = erb_pkg::erb_depth(ctrl_q.wr_shape);
    assign depth_last = 9'(wr_depth - 10'h001);

    // ***********************************************************
    // Clock selection
    // ***********************************************************
    assign wr_ce = ctrl_q.wr_clk_sel ? clk1_ce : clk0_ce; // [R8]
    assign rd_ce = ctrl_q.rd_en_clk_sel ? clk1_ce : clk0_ce; // [R9]
    assign out_ce = ctrl_q.out_clk_sel ? clk1_ce : clk0_ce; // [R9]

    // ***********************************************************
    // Write side
    // ***********************************************************
    // Left neighbour carries the low sixteen bits, right the top pair, bits 17:16
    assign wr_word = {din_right[1:0], din_left}; // [R14]

    // Writes are blocked while the input clear is held
    assign wr_fire = ctrl_q.run && !in_clr && wr_ce && user.wr_en && !is_rom; // [R18]
    assign push = wr_fire && is_fifo && !full_q;

    always_comb begin
        if (is_fifo) begin
            wr_addr_eff = wr_ptr_q;
        end else if (is_shift) begin
            wr_addr_eff = sh_ptr_q;
        end else begin
            wr_addr_eff = user.wr_addr;
        end
    end

    erb_lane u_wr_lane (
        .shape(ctrl_q.wr_shape),
        .addr(wr_addr_eff),
        .row_in(mem_q[w_row]),
        .wdata(wr_word),
        .row_idx(w_row),
        .rdata(),
        .row_wr(w_row_wr)
    );

    // ***********************************************************
    // Storage
    // ***********************************************************
    // No reset on the array; contents are undefined until written or preloaded
    always_ff @(posedge pclk) begin
        if (apb_commit && pwrite && apb_off == erb_pkg::ERB_OFF_INIT_DATA && preload_ok) begin
            mem_q[init_row_q] <= pwdata[17:0]; // [R11]
        end else if (wr_fire && (!is_fifo || push)) begin
            mem_q[w_row] <= w_row_wr; // [R15]
        end
    end

    // ***********************************************************
    // Read side input registers
    // ***********************************************************
    always_comb begin
        if (is_fifo) begin
            rd_addr_in = rd_ptr_q;
        end else if (is_shift) begin
            rd_addr_in = (sh_ptr_q == depth_last) ? 9'h000 : 9'(sh_ptr_q + 9'h001);
        end else if (is_sp) begin
            rd_addr_in = user.wr_addr;
        end else begin
            rd_addr_in = user.rd_addr;
        end
    end

    // Address and read strobe are always registered; there is no bypass
    erb_port_reg #(.W(9)) u_rd_addr_reg (
        .pclk(pclk),
        .presetn(presetn),
        .clr(in_clr),
        .ce0(clk0_ce),
        .ce1(clk1_ce),
        .sel(ctrl_q.rd_addr_clk_sel),
        .d(rd_addr_in),
        .q(rd_addr_q)
    ); // [R10]

    erb_port_reg #(.W(1)) u_rd_en_reg (
        .pclk(pclk),
        .presetn(presetn),
        .clr(in_clr),
        .ce0(clk0_ce),
        .ce1(clk1_ce),
        .sel(ctrl_q.rd_en_clk_sel),
        .d(ctrl_q.run && (user.rd_en || is_shift)),
        .q(rd_en_q)
    ); // [R10]

    erb_lane u_rd_lane (
        .shape(rd_shape),
        .addr(rd_addr_q),
        .row_in(mem_q[r_row]),
        .wdata(18'h00000),
        .row_idx(r_row),
        .rdata(r_word),
        .row_wr()
    );

    // ***********************************************************
    // Output register
    // ***********************************************************
    // Clear is visible at once; an input clear also clears rd_en_q, so the
    // output keeps its value until a new read strobe is registered
    always_ff @(posedge pclk or negedge presetn or posedge out_clr) begin
        if (!presetn) begin
            dout_q <= '0;
        end else if (out_clr) begin
            dout_q <= '0; // [R7]
        end else if (rd_en_q && (ctrl_q.out_bypass || out_ce)) begin
            dout_q <= r_word; // [R17] [R6]
        end
    end

    assign dout_left = dout_q; // [R14]
    assign dout_right = dout_q;

    // ***********************************************************
    // FIFO pointers and flags
    // ***********************************************************
    assign pop = is_fifo && ctrl_q.run && !in_clr && rd_ce && user.rd_en && !empty_q;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = 10'(cnt_q + 10'h001);
        end else if (pop && !push) begin
            cnt_d = 10'(cnt_q - 10'h001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else if (!is_fifo || !ctrl_q.run) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == depth_last) ? 9'h000 : 9'(wr_ptr_q + 9'h001);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == depth_last) ? 9'h000 : 9'(rd_ptr_q + 9'h001);
            end
            cnt_q <= cnt_d;
            full_q <= (cnt_d == wr_depth);
            empty_q <= (cnt_d == 10'h000);
        end
    end

    assign fifo_full = full_q;
    assign fifo_empty = empty_q;

    // ***********************************************************
    // Shift register tap pointer
    // ***********************************************************
    // Tap reads the word after the write slot, the oldest in the line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ptr_q <= '0;
        end else if (!is_shift || !ctrl_q.run) begin
            sh_ptr_q <= '0;
        end else if (wr_fire) begin
            sh_ptr_q <= (sh_ptr_q == depth_last) ? 9'h000 : 9'(sh_ptr_q + 9'h001);
        end
    end

    // ***********************************************************
    // APB slave
    // ***********************************************************
    // One wait state: pready rises in the second access cycle
    assign apb_access = psel && penable && !pready_q;
    assign apb_commit = psel && penable && pready_q;
    assign apb_off = {paddr[11:2], 2'b00};
    assign preload_ok = !ctrl_q.run && !is_fifo && !is_shift; // [R11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (apb_access) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            case (apb_off)
                erb_pkg::ERB_OFF_CTRL: prdata_q <= 32'(ctrl_q);
                erb_pkg::ERB_OFF_STATUS: prdata_q <= {20'h00000, cnt_q,
                                                      full_q, empty_q};
                erb_pkg::ERB_OFF_INIT_ADDR: prdata_q <= {27'h0000000, init_row_q};
                erb_pkg::ERB_OFF_INIT_DATA: prdata_q <= {14'h0000, mem_q[init_row_q]};
                default: pslverr_q <= 1'b1;
            endcase
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= erb_pkg::ERB_CTRL_RST;
        end else if (apb_commit && pwrite && apb_off == erb_pkg::ERB_OFF_CTRL) begin
            ctrl_q <= pwdata[erb_pkg::ERB_CTRL_W-1:0];
        end
    end

    // Row pointer steps after each preload or row read for burst loading
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_row_q <= '0;
        end else if (apb_commit && pwrite && apb_off == erb_pkg::ERB_OFF_INIT_ADDR) begin
            init_row_q <= pwdata[4:0];
        end else if (apb_commit && apb_off == erb_pkg::ERB_OFF_INIT_DATA) begin
            init_row_q <= 5'(init_row_q + 5'h01);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule
`default_nettype wire

//--- sim/erb_ram_monitor.sv
// Checker for the small RAM block: APB answers, output clears, output hold.
// Assumes it is bound into every erb_ram and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module erb_ram_monitor (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Block clocks and clear
    input wire logic clk0_ce,
    input wire logic clk1_ce,
    input wire logic out_clr,
    // Outputs
    input wire logic [17:0] dout_left,
    input wire logic [17:0] dout_right,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    logic [16:0] ctrl_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ***********************************************************
    // Shadow of the control register
    // ***********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 17'h086c1;
        end else if (psel && penable && pready && pwrite && paddr[11:2] == 10'h000) begin
            ctrl_q <= pwdata[16:0];
        end
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    a_out_clear_now: assert property (out_clr |-> dout_left == 18'h0)
        else $error("output not cleared while out_clr high");
    a_both_sides: assert property (dout_left == dout_right)
        else $error("left and right outputs differ");
    a_ready_timing: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_decode: assert property (psel && penable && pready
        |-> pslverr == (paddr[11:2] > 10'h003))
        else $error("pslverr does not match address decode");
    a_flags_excl: assert property (!(fifo_full && fifo_empty))
        else $error("fifo full and empty together");
    a_flags_idle: assert property ((ctrl_q[4:0] != 5'h04) [*2]
        |-> fifo_empty && !fifo_full)
        else $error("fifo flags active outside fifo mode");
    a_output_hold: assert property ((!ctrl_q[11] && !clk0_ce && !clk1_ce && !out_clr)
        ##1 !out_clr |-> $stable(dout_left))
        else $error("registered output moved without a clock");

    c_out_clear: cover property (out_clr);
    c_slverr: cover property (pready && pslverr);
    c_fifo_data: cover property (!fifo_empty);
endmodule

bind erb_ram erb_ram_monitor erb_ram_monitor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .clk0_ce(clk0_ce), .clk1_ce(clk1_ce),
    .out_clr(out_clr), .dout_left(dout_left), .dout_right(dout_right),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty));
`default_nettype wire

//--- sim/erb_nbr_model.sv
// Neighbour cluster logic: turns one-cycle requests into a strobe cycle.
// Assumes requests are single pulses; released lines show the inverse.
`timescale 1ns/1ps
`default_nettype none
module erb_nbr_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests
    input wire logic op_wr,
    input wire logic op_rd,
    input wire logic [8:0] op_addr,
    input wire logic [17:0] op_data,
    // Toward the block
    output logic clk0_ce,
    output erb_pkg::erb_user_s user,
    output logic [15:0] din_left,
    output logic [15:0] din_right
);
    logic ce_q, wr_q, rd_q;
    logic [8:0] a_q;
    logic [17:0] d_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ce_q, wr_q, rd_q, a_q, d_q} <= '0;
        end else begin
            ce_q <= op_wr | op_rd;
            wr_q <= op_wr;
            rd_q <= op_rd;
            if (op_wr || op_rd) begin
                a_q <= op_addr;
                d_q <= op_data;
            end
        end
    end

    // Strobes, address and data share the one clock pulse
    assign clk0_ce = ce_q;
    assign user = '{wr_en: wr_q, rd_en: rd_q, wr_addr: ce_q ? a_q : ~a_q,
        rd_addr: ce_q ? a_q : ~a_q};
    assign {din_right, din_left} = {14'h0, ce_q ? d_q : ~d_q};
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the small RAM block over APB and a neighbour.
// Assumes the erb_nbr_model partner and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic clk0_ce, clk1_ce, in_clr, out_clr, fifo_full, fifo_empty, op_wr, op_rd;
    logic [15:0] din_left, din_right;
    logic [17:0] dout_left, dout_right, op_data;
    logic [8:0] op_addr;
    erb_pkg::erb_user_s user;
    int n_fail, checks_done, cyc;
    int wd[7] = '{1, 2, 4, 8, 9, 16, 18};

    erb_ram erb_ram_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk0_ce(clk0_ce), .clk1_ce(clk1_ce), .in_clr(in_clr),
        .out_clr(out_clr), .din_left(din_left), .din_right(din_right), .user(user),
        .dout_left(dout_left), .dout_right(dout_right), .fifo_full(fifo_full),
        .fifo_empty(fifo_empty));
    erb_nbr_model erb_nbr_model_i (.pclk(pclk), .presetn(presetn), .op_wr(op_wr),
        .op_rd(op_rd), .op_addr(op_addr), .op_data(op_data), .clk0_ce(clk0_ce),
        .user(user), .din_left(din_left), .din_right(din_right));
    // ***********************************************************
    // Tasks
    // ***********************************************************
    task automatic wrap_up;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic uop(input logic w, input logic [8:0] a, input logic [17:0] d);
        op_wr <= w;
        op_rd <= !w;
        op_addr <= a;
        op_data <= d;
        @(posedge pclk);
        op_wr <= 1'b0;
        op_rd <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic pulse1;
        clk1_ce <= 1'b1;
        @(posedge pclk);
        clk1_ce <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic [31:0] ctl(input logic [4:0] m, input logic [2:0] s, r,
        input logic b, o);
        ctl = {15'h0, 1'b1, o, 3'h0, b, r, s, m};
    endfunction

    // ***********************************************************
    // Clock, timeout and sequence
    // ***********************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, clk1_ce, in_clr, out_clr, op_wr, op_rd} = '0;
        {paddr, pwdata, op_addr, op_data} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h000, 32'h000086c1, "ctrl reset");
        rdc(12'h004, 32'h00000001, "status reset");
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        // Preload, then a preload in shift mode that must be ignored
        apb(1'b1, 12'h008, 32'h5);
        apb(1'b1, 12'h00c, 32'h2a5f3);
        rdc(12'h008, 32'h6, "init addr step");
        apb(1'b1, 12'h000, ctl(5'h10, 3'h6, 3'h6, 1'b0, 1'b1) ^ 32'h10000);
        apb(1'b1, 12'h008, 32'h5);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h008, 32'h5);
        rdc(12'h00c, 32'h2a5f3, "row five");
        // Read-only use refuses user writes
        apb(1'b1, 12'h000, ctl(5'h08, 3'h6, 3'h6, 1'b1, 1'b0));
        uop(1'b1, 9'h5, 18'h0);
        uop(1'b0, 9'h5, 18'h0);
        chk("rom read", 32'h2a5f3, {14'h0, dout_left});
        // Every shape, alternating simple dual-port and single-port
        for (int s = 0; s < 7; s++) begin
            apb(1'b1, 12'h000, ctl(s[0] ? 5'h02 : 5'h01, s[2:0], s[2:0], 1'b1, 1'b0));
            uop(1'b1, 9'h3, 18'h3ffff);
            uop(1'b0, 9'h3, 18'h0);
            chk("shape", (32'h1 << wd[s]) - 32'h1, {14'h0, dout_left});
        end
        // Mixed widths: 18-bit write, 9-bit read of the upper half
        apb(1'b1, 12'h000, ctl(5'h01, 3'h6, 3'h4, 1'b1, 1'b0));
        uop(1'b1, 9'h0, 18'h2a5f3);
        uop(1'b0, 9'h1, 18'h0);
        chk("mixed", 32'h2a5f3 >> 9, {14'h0, dout_left});
        // Registered output on the other clock waits for its edge
        apb(1'b1, 12'h000, ctl(5'h01, 3'h6, 3'h6, 1'b0, 1'b1));
        uop(1'b0, 9'h0, 18'h0);
        chk("held", 32'h152, {14'h0, dout_left});
        pulse1();
        chk("out edge", 32'h2a5f3, {14'h0, dout_left});
        in_clr <= 1'b1;
        #1 chk("in clr", 32'h2a5f3, {14'h0, dout_left});
        @(posedge pclk);
        in_clr <= 1'b0;
        out_clr <= 1'b1;
        #1 chk("out clr", 32'h0, {14'h0, dout_left});
        @(posedge pclk);
        out_clr <= 1'b0;
        @(posedge pclk);
        // FIFO: two pushes, one pop
        apb(1'b1, 12'h000, ctl(5'h04, 3'h6, 3'h6, 1'b0, 1'b1));
        uop(1'b1, 9'h0, 18'h11111);
        uop(1'b1, 9'h0, 18'h22222);
        rdc(12'h004, 32'h8, "fifo two");
        chk("fifo flags", 32'h0, {30'h0, fifo_full, fifo_empty});
        uop(1'b0, 9'h0, 18'h0);
        pulse1();
        chk("fifo pop", 32'h11111, {14'h0, dout_left});
        rdc(12'h004, 32'h4, "fifo one");
        wrap_up();
    end
endmodule
`default_nettype wire
